// >>> logic/gain_lane_if.sv
`timescale 1ns/1ps
interface gain_lane_if #(parameter int DW = 24);
	logic inValid;
	logic signed [DW-1:0] inSample;
	logic [3:0] fine;
	logic [3:0] coarse;
	logic outValid;
	logic signed [DW-1:0] outSample;
	modport feeder (output inValid, inSample, fine, coarse, input outValid, outSample);
	modport scaler (input inValid, inSample, fine, coarse, output outValid, outSample);
endinterface

// >>> logic/playback_dac_rate_volume.sv
`timescale 1ns/1ps
module playback_dac_rate_volume import playback_pkg::*; #(
	parameter int ADDR_W = 18,
	parameter int DW = 24
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	output logic dacClkEn,
	output logic dacValid,
	output logic [DW-1:0] dacLeft,
	output logic [DW-1:0] dacRight
);
	localparam int DIV_W = $clog2(INTERP_DIV);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INTERP_DIV - 1);

	// byte-lane merge for a 16-bit register
	function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = d[7:0];
		end
		if (strb[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// 24-bit sample from high word and upper byte of low register
	function automatic logic signed [DW-1:0] joinSample(input logic [15:0] hi, input logic [15:0] lo);
		return {hi, lo[LOW_BYTE_MSB:LOW_BYTE_LSB]};
	endfunction

	function automatic logic isMapped(input logic [15:0] idx);
		return idx inside {IDX_RATE_LOW, IDX_RATE_HIGH, IDX_LEFT_LOW, IDX_LEFT_HIGH, IDX_RIGHT_LOW,
			IDX_RIGHT_HIGH, IDX_VOLUME, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_PATH_STATUS};
	endfunction

	logic [15:0] rateLow_reg;
	logic [RATE_HIGH_W-1:0] rateHigh_reg;
	logic [15:0] leftLow_reg;
	logic [15:0] leftHigh_reg;
	logic [15:0] rightLow_reg;
	logic [15:0] rightHigh_reg;
	logic [15:0] volume_reg;
	logic [1:0] irqStatus_reg;
	logic [1:0] irqMask_reg;
	logic [3:0] written_reg;

	logic awHeld_reg;
	logic wHeld_reg;
	logic [ADDR_W-1:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;

	logic [RATE_W-1:0] rateInc;
	logic idle;
	logic [DIV_W-1:0] prescale_reg;
	logic [RATE_W-1:0] acc_reg;
	logic interpTick;
	logic rollover;
	logic [RATE_W:0] accSum;

	logic signed [DW-1:0] curLeft_reg;
	logic signed [DW-1:0] curRight_reg;
	logic signed [DW-1:0] prevLeft_reg;
	logic signed [DW-1:0] prevRight_reg;
	logic signed [DW-1:0] upLeft_reg;
	logic signed [DW-1:0] upRight_reg;
	logic upValid_reg;

	logic doWrite;
	logic [15:0] wIdx;
	logic [15:0] rIdx;
	logic [15:0] rdWord;
	logic [1:0] statusSet;
	logic [1:0] statusClr;

	gain_lane_if #(.DW(DW)) leftLane ();
	gain_lane_if #(.DW(DW)) rightLane ();

	assign rateInc = {rateHigh_reg, rateLow_reg};
	assign idle = (rateInc == '0);
	assign dacClkEn = !idle;
	assign interpTick = !idle && (prescale_reg == DIV_LAST);
	assign accSum = {1'b0, acc_reg} + {1'b0, rateInc};
	assign rollover = interpTick && accSum[RATE_W];

	// axi write channel: address and data taken in either order
	assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
	assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
	assign wIdx = awAddr_reg[17:2];

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= '0;
			wData_reg <= '0;
			wStrb_reg <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= isMapped(wIdx) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register file
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rateLow_reg <= RST_REG16;
			rateHigh_reg <= RST_REG4;
			leftLow_reg <= RST_REG16;
			leftHigh_reg <= RST_REG16;
			rightLow_reg <= RST_REG16;
			rightHigh_reg <= RST_REG16;
			volume_reg <= RST_REG16;
			irqMask_reg <= RST_IRQ;
		end else if (ce && doWrite) begin
			unique case (wIdx)
				IDX_RATE_LOW: rateLow_reg <= laneMerge(rateLow_reg, wData_reg, wStrb_reg);
				IDX_RATE_HIGH: begin
					if (wStrb_reg[0]) begin
						rateHigh_reg <= wData_reg[RATE_HIGH_W-1:0];
					end
				end
				IDX_LEFT_LOW: leftLow_reg <= laneMerge(leftLow_reg, wData_reg, wStrb_reg);
				IDX_LEFT_HIGH: leftHigh_reg <= laneMerge(leftHigh_reg, wData_reg, wStrb_reg);
				IDX_RIGHT_LOW: rightLow_reg <= laneMerge(rightLow_reg, wData_reg, wStrb_reg);
				IDX_RIGHT_HIGH: rightHigh_reg <= laneMerge(rightHigh_reg, wData_reg, wStrb_reg);
				IDX_VOLUME: volume_reg <= laneMerge(volume_reg, wData_reg, wStrb_reg);
				IDX_IRQ_MASK: begin
					if (wStrb_reg[0]) begin
						irqMask_reg <= wData_reg[1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// tracks which sample words were refreshed since the last rollover
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			written_reg <= 4'h0;
		end else if (ce) begin
			logic [3:0] hit;
			hit = 4'h0;
			if (doWrite) begin
				hit[0] = (wIdx == IDX_LEFT_LOW);
				hit[1] = (wIdx == IDX_LEFT_HIGH);
				hit[2] = (wIdx == IDX_RIGHT_LOW);
				hit[3] = (wIdx == IDX_RIGHT_HIGH);
			end
			written_reg <= rollover ? hit : (written_reg | hit);
		end
	end

	// sticky events, write one to clear, set wins
	always_comb begin
		statusSet = 2'h0;
		statusSet[IRQ_REQ_BIT] = rollover;
		statusSet[IRQ_URUN_BIT] = rollover && (written_reg != 4'hF);
		statusClr = 2'h0;
		if (doWrite && wIdx == IDX_IRQ_STATUS && wStrb_reg[0]) begin
			statusClr = wData_reg[1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irqStatus_reg <= RST_IRQ;
		end else if (ce) begin
			irqStatus_reg <= (irqStatus_reg & ~statusClr) | statusSet;
		end
	end

	assign irq = |(irqStatus_reg & irqMask_reg);

	// axi read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign rIdx = s_axi_araddr[17:2];

	always_comb begin
		rdWord = 16'h0000;
		unique case (rIdx)
			IDX_RATE_LOW: rdWord = rateLow_reg;
			IDX_RATE_HIGH: rdWord = {12'h000, rateHigh_reg};
			IDX_LEFT_LOW: rdWord = leftLow_reg;
			IDX_LEFT_HIGH: rdWord = leftHigh_reg;
			IDX_RIGHT_LOW: rdWord = rightLow_reg;
			IDX_RIGHT_HIGH: rdWord = rightHigh_reg;
			IDX_VOLUME: rdWord = volume_reg;
			IDX_IRQ_STATUS: rdWord = {14'h0000, irqStatus_reg};
			IDX_IRQ_MASK: rdWord = {14'h0000, irqMask_reg};
			IDX_PATH_STATUS: rdWord = {14'h0000, dacClkEn, idle};
			default: rdWord = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {16'h0000, rdWord};
				s_axi_rresp <= isMapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// interpolator clock prescaler and phase accumulator, held in idle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prescale_reg <= '0;
			acc_reg <= '0;
		end else if (ce && !idle) begin
			prescale_reg <= interpTick ? '0 : prescale_reg + DIV_W'(1);
			if (interpTick) begin
				acc_reg <= accSum[RATE_W-1:0];
			end
		end
	end

	// on rollover the written sample becomes current, the old one previous
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			curLeft_reg <= '0;
			curRight_reg <= '0;
			prevLeft_reg <= '0;
			prevRight_reg <= '0;
		end else if (ce && rollover) begin
			prevLeft_reg <= curLeft_reg;
			prevRight_reg <= curRight_reg;
			curLeft_reg <= joinSample(leftHigh_reg, leftLow_reg);
			curRight_reg <= joinSample(rightHigh_reg, rightLow_reg);
		end
	end

	// linear upconverter, phase taken from the accumulator top bits
	function automatic logic signed [DW-1:0] interp(input logic signed [DW-1:0] a,
		input logic signed [DW-1:0] b, input logic [FRAC_W-1:0] ph);
		logic signed [DW:0] delta;
		logic signed [DW+FRAC_W+1:0] step;
		delta = $signed({b[DW-1], b}) - $signed({a[DW-1], a});
		step = (delta * $signed({1'b0, ph})) >>> FRAC_W;
		return a + step[DW-1:0];
	endfunction

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			upLeft_reg <= '0;
			upRight_reg <= '0;
			upValid_reg <= 1'b0;
		end else if (ce) begin
			upValid_reg <= interpTick;
			if (interpTick) begin
				upLeft_reg <= interp(prevLeft_reg, curLeft_reg, acc_reg[RATE_W-1 -: FRAC_W]);
				upRight_reg <= interp(prevRight_reg, curRight_reg, acc_reg[RATE_W-1 -: FRAC_W]);
			end
		end
	end

	// volume after upconversion
	assign leftLane.inValid = upValid_reg;
	assign leftLane.inSample = upLeft_reg;
	assign leftLane.fine = volume_reg[VOL_LFINE_LSB +: 4];
	assign leftLane.coarse = volume_reg[VOL_LCOARSE_LSB +: 4];
	assign rightLane.inValid = upValid_reg;
	assign rightLane.inSample = upRight_reg;
	assign rightLane.fine = volume_reg[VOL_RFINE_LSB +: 4];
	assign rightLane.coarse = volume_reg[VOL_RCOARSE_LSB +: 4];

	volume_scaler #(.DW(DW)) leftScale (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.lane(leftLane)
	);

	volume_scaler #(.DW(DW)) rightScale (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.lane(rightLane)
	);

	// converter feed
	assign dacValid = leftLane.outValid;
	assign dacLeft = leftLane.outSample;
	assign dacRight = rightLane.outSample;
endmodule

// >>> logic/playback_pkg.sv
package playback_pkg;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_RATE_LOW = 16'hFC34;
	localparam logic [15:0] IDX_RATE_HIGH = 16'hFC35;
	localparam logic [15:0] IDX_LEFT_LOW = 16'hFC36;
	localparam logic [15:0] IDX_LEFT_HIGH = 16'hFC37;
	localparam logic [15:0] IDX_RIGHT_LOW = 16'hFC38;
	localparam logic [15:0] IDX_RIGHT_HIGH = 16'hFC39;
	localparam logic [15:0] IDX_VOLUME = 16'hFEC0;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'hFC30;
	localparam logic [15:0] IDX_IRQ_MASK = 16'hFC31;
	localparam logic [15:0] IDX_PATH_STATUS = 16'hFC32;
	// reset values
	localparam logic [15:0] RST_REG16 = 16'h0000;
	localparam logic [3:0] RST_REG4 = 4'h0;
	localparam logic [1:0] RST_IRQ = 2'h0;
	// field positions
	localparam int RATE_HIGH_W = 4;
	localparam int RATE_W = 20;
	localparam int LOW_BYTE_MSB = 15;
	localparam int LOW_BYTE_LSB = 8;
	localparam int VOL_LFINE_LSB = 12;
	localparam int VOL_LCOARSE_LSB = 8;
	localparam int VOL_RFINE_LSB = 4;
	localparam int VOL_RCOARSE_LSB = 0;
	localparam int IRQ_REQ_BIT = 0;
	localparam int IRQ_URUN_BIT = 1;
	localparam int PSTAT_IDLE_BIT = 0;
	localparam int PSTAT_CLKEN_BIT = 1;
	// timing: fs = clk / 2^27 * increment, accumulator is 2^20
	localparam int RATE_SCALE_LOG2 = 27;
	localparam int INTERP_DIV = 2 ** (RATE_SCALE_LOG2 - RATE_W);
	localparam int XTAL_HZ = 40_000_000;
	localparam int MAX_FS_HZ = 96_000;
	localparam logic [19:0] MAX_RATE_INC = 20'(MAX_FS_HZ * 64'h8000000 / XTAL_HZ);
	localparam int FRAC_W = 8;
	localparam int GAIN_FRAC = 14;
	localparam logic [3:0] FINE_MAX = 4'hB;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/volume_scaler.sv
`timescale 1ns/1ps
module volume_scaler import playback_pkg::*; #(
	parameter int DW = 24
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	gain_lane_if.scaler lane
);
	// fine boost in steps of 0.5 dB, q2.14
	function automatic logic [15:0] fineGain(input logic [3:0] f);
		logic [15:0] g;
		g = 16'h4000;
		unique case (f)
			4'h0: g = 16'h4000;
			4'h1: g = 16'h43CB;
			4'h2: g = 16'h47CF;
			4'h3: g = 16'h4C10;
			4'h4: g = 16'h5092;
			4'h5: g = 16'h5559;
			4'h6: g = 16'h5A67;
			4'h7: g = 16'h5FC3;
			4'h8: g = 16'h6570;
			4'h9: g = 16'h6B73;
			4'hA: g = 16'h71D1;
			4'hB: g = 16'h7890;
			default: g = 16'h4000;
		endcase
		return g;
	endfunction

	localparam logic signed [DW+17:0] POS_LIM = (DW+18)'(2 ** (DW - 1) - 1);
	localparam logic signed [DW+17:0] NEG_LIM = -(DW+18)'(2 ** (DW - 1));

	logic signed [DW+17:0] boosted;
	logic signed [DW+17:0] cut;

	always_comb begin
		boosted = (lane.inSample * $signed({2'h0, fineGain(lane.fine)})) >>> GAIN_FRAC;
		cut = boosted >>> lane.coarse;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lane.outValid <= 1'b0;
			lane.outSample <= '0;
		end else if (ce) begin
			lane.outValid <= lane.inValid;
			if (lane.inValid) begin
				if (cut > POS_LIM) begin
					lane.outSample <= POS_LIM[DW-1:0];
				end else if (cut < NEG_LIM) begin
					lane.outSample <= NEG_LIM[DW-1:0];
				end else begin
					lane.outSample <= cut[DW-1:0];
				end
			end
		end
	end
endmodule

// >>> tb/dac_path_monitor.sv
`timescale 1ns/1ps
module dac_path_monitor import playback_pkg::*; #(
	parameter int DW = 24
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq,
	input wire logic dacClkEn,
	input wire logic dacValid,
	input wire logic [DW-1:0] dacLeft,
	input wire logic [DW-1:0] dacRight
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] gap;
	logic run;
	// enabled cycles since the last output sample while the path keeps running
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !dacClkEn) begin
			gap <= 8'h00;
			run <= 1'b0;
		end else if (ce && dacValid) begin
			gap <= 8'h00;
			run <= 1'b1;
		end else if (ce) begin
			gap <= gap + 8'h01;
		end
	end
	a_reset_quiet: assert property ($rose(rst_n) |-> !irq && !dacClkEn && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not quiet after reset");
	a_idle_silent: assert property (!dacClkEn [*4] |-> !dacValid)
		else $error("output sample while idle");
	a_tick_spacing: assert property (dacValid && run |-> gap == 8'h7F)
		else $error("output samples not 128 cycles apart");
	a_data_with_valid: assert property ($changed(dacLeft) || $changed(dacRight) |-> dacValid)
		else $error("output data changed without valid");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	cover property (dacValid && run);
	cover property ($rose(irq));
	cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind playback_dac_rate_volume dac_path_monitor #(.DW(DW)) i_dac_path_monitor (.sys_clk, .rst_n,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.ce, .irq, .dacClkEn, .dacValid, .dacLeft, .dacRight);

// >>> tb/host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model import playback_pkg::*; (
	input wire logic sys_clk,
	output logic [17:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [17:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	int slow = 0;
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
	end
	task automatic wr(input logic [15:0] idx, input logic [15:0] d, output logic [1:0] resp);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge sys_clk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~s_axi_awaddr;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~s_axi_wdata;
			end
		end
		repeat (slow) @(posedge sys_clk);
		s_axi_bready <= 1'b1;
		@(posedge sys_clk);
		while (!s_axi_bvalid) @(posedge sys_clk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] resp);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		@(posedge sys_clk);
		while (!s_axi_arready) @(posedge sys_clk);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~s_axi_araddr;
		repeat (slow) @(posedge sys_clk);
		s_axi_rready <= 1'b1;
		@(posedge sys_clk);
		while (!s_axi_rvalid) @(posedge sys_clk);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// answer one sample request: both words of both channels, then clear it
	task automatic serve(input logic [23:0] l, input logic [23:0] r);
		logic [1:0] rs;
		wr(IDX_LEFT_LOW, {l[7:0], 8'h00}, rs);
		wr(IDX_LEFT_HIGH, l[23:8], rs);
		wr(IDX_RIGHT_LOW, {r[7:0], 8'h00}, rs);
		wr(IDX_RIGHT_HIGH, r[23:8], rs);
		wr(IDX_IRQ_STATUS, 16'h0001, rs);
	endtask
endmodule

// >>> tb/test_playback_dac_rate_volume.sv
`timescale 1ns/1ps
module test_playback_dac_rate_volume import playback_pkg::*;;
	typedef struct {logic [15:0] idx; logic [15:0] d; logic [31:0] q; logic [1:0] r;} row_s;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, dacClkEn, dacValid;
	logic [23:0] dacLeft, dacRight;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int t0;
	real g;
	row_s rows[8] = '{'{IDX_VOLUME, 16'hC100, 32'h0000C100, RESP_OKAY},
		'{IDX_LEFT_LOW, 16'h0000, 32'h0, RESP_OKAY}, '{IDX_LEFT_HIGH, 16'h4000, 32'h4000, RESP_OKAY},
		'{IDX_RIGHT_LOW, 16'h1200, 32'h1200, RESP_OKAY},
		'{IDX_RIGHT_HIGH, 16'h4000, 32'h4000, RESP_OKAY},
		'{16'h0123, 16'h5555, 32'h0, RESP_SLVERR}, '{IDX_IRQ_MASK, 16'h0001, 32'h1, RESP_OKAY},
		'{IDX_RATE_HIGH, 16'hFFF8, 32'h8, RESP_OKAY}};
	always #12.5 sys_clk = ~sys_clk;
	playback_dac_rate_volume i_playback_dac_rate_volume (.sys_clk, .rst_n, .ce, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq, .dacClkEn, .dacValid, .dacLeft, .dacRight);
	host_cpu_model i_host_cpu_model (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk("idle after reset", {30'h0, irq, dacClkEn}, 32'h0);
		foreach (rows[i]) begin
			i_host_cpu_model.rd(rows[i].idx, q, rs);
			chk("reset value", q, 32'h0);
			i_host_cpu_model.wr(rows[i].idx, rows[i].d, rs);
			chk("write resp", {30'h0, rs}, {30'h0, rows[i].r});
			i_host_cpu_model.rd(rows[i].idx, q, rs);
			chk("readback", q, rows[i].q);
			chk("read resp", {30'h0, rs}, {30'h0, rows[i].r});
		end
		$display("test registers done");
		for (int k = 0; k < 4; k++) begin
			while (!irq) @(posedge sys_clk);
			if (k == 1) t0 = cyc;
			if (k == 3) chk("request period", cyc - t0, 32'h200);
			i_host_cpu_model.serve(24'h400000, 24'h400012);
		end
		$display("test rate done");
		@(posedge sys_clk);
		while (!dacValid) @(posedge sys_clk);
		chk("left scaled", {8'h0, dacLeft}, 32'h200000);
		chk("right sample", {8'h0, dacRight}, 32'h400012);
		$display("test volume done");
		@(posedge sys_clk);
		while (!dacValid) @(posedge sys_clk);
		ce <= 1'b0;
		q = {31'h0, irq};
		t0 = 0;
		repeat (300) begin
			@(posedge sys_clk);
			t0 += dacValid;
		end
		chk("frozen samples", t0, 32'h0);
		chk("frozen request", {31'h0, irq}, q);
		ce <= 1'b1;
		$display("test freeze done");
		i_host_cpu_model.wr(IDX_VOLUME, 16'hC1B2, rs);
		@(posedge sys_clk);
		while (!dacValid) @(posedge sys_clk);
		g = 4194322.0 * (10.0 ** (11 * 0.5 / 20.0)) / 4.0;
		chk("right fine", {31'h0, (dacRight > g * 0.999) && (dacRight < g * 1.001)}, 32'h1);
		chk("left unchanged", {8'h0, dacLeft}, 32'h200000);
		$display("test fine done");
		i_host_cpu_model.slow = 3;
		i_host_cpu_model.wr(IDX_RATE_HIGH, 16'h0000, rs);
		i_host_cpu_model.wr(IDX_IRQ_STATUS, 16'h0003, rs);
		@(posedge sys_clk);
		chk("clock halted", {31'h0, dacClkEn}, 32'h0);
		i_host_cpu_model.rd(IDX_PATH_STATUS, q, rs);
		chk("path idle", q, 32'h1);
		repeat (600) @(posedge sys_clk);
		chk("no request idle", {31'h0, irq}, 32'h0);
		$display("test idle done");
		report_and_stop();
	end
endmodule
